/* File: hw/bsf_host.sv */
// Host controller driving a parallel boot sector NOR flash from APB registers
// Summary of operation
// - Word mode uses all sixteen data lanes; byte mode only the low eight.
// - Host uses chip select, write strobe, output drive so buses never clash.
// - Commands are ordinary bus writes to the device command register.
// - Host may put the device in low-power standby.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module bsf_host #(
  parameter int ADDR_W = 22,
  parameter int POLL_LIMIT = 65535
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash address and controls
  output logic [ADDR_W-1:0] flash_addr,
  output logic chip_sel_n,
  output logic write_n,
  output logic out_en_n,
  output logic byte_mode_n,
  output logic flash_reset_n,
  output logic write_protect_n,
  output logic fast_program_input,
  // Flash data lanes, three signals per pin
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe_n,
  // Device status pin
  input wire logic ready_busy_n
);
  localparam int CNT_W_L = bsf_pkg::CNT_W;
  localparam logic [CNT_W_L-1:0] SETUP_L = CNT_W_L'(bsf_pkg::SETUP_CYC);
  localparam logic [CNT_W_L-1:0] ACCESS_L = CNT_W_L'(bsf_pkg::ACCESS_CYC);
  localparam logic [CNT_W_L-1:0] STROBE_L = CNT_W_L'(bsf_pkg::STROBE_CYC);
  localparam logic [CNT_W_L-1:0] HOLD_L = CNT_W_L'(bsf_pkg::HOLD_CYC);
  localparam logic [CNT_W_L-1:0] RESET_L = CNT_W_L'(bsf_pkg::RESET_CYC);
  // Later poll reads carry one released cycle ahead of the full access window
  localparam logic [CNT_W_L-1:0] POLL_L = CNT_W_L'(bsf_pkg::ACCESS_CYC + 1);

  if (ADDR_W < 21 || ADDR_W > 32)
  begin
    $error("bsf_host: ADDR_W must be 21..32");
  end
  if (POLL_LIMIT < 2 || POLL_LIMIT > 65535)
  begin
    $error("bsf_host: POLL_LIMIT out of range");
  end

  bsf_pkg::bsf_state_t state_r;
  bsf_pkg::bsf_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [31:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic done_r;
  logic pollerr_r;
  logic toggle_r;
  logic [15:0] poll_cnt_r;
  logic [15:0] prev_r;
  logic first_r;
  logic tmr_load;
  logic [CNT_W_L-1:0] tmr_count;
  logic tmr_exp;
  logic apb_wr;
  logic go;
  logic busy;
  logic byte_mode;
  logic is_write;
  logic polling;
  logic [15:0] lane_mask;

  assign apb_wr = psel && penable && pwrite;
  assign go = apb_wr && paddr == bsf_pkg::CTRL_OFS && pwdata[bsf_pkg::CTRL_GO_BIT];
  assign busy = state_r != bsf_pkg::ST_IDLE;
  assign byte_mode = ctrl_r[bsf_pkg::CTRL_BYTE_BIT];
  assign is_write = ctrl_r[bsf_pkg::CTRL_WR_BIT];
  assign polling = ctrl_r[bsf_pkg::CTRL_POLL_BIT];
  // Byte mode keeps the upper lanes out of play
  assign lane_mask = byte_mode ? 16'h00ff : 16'hffff;

  // APB answers at once; unmapped offsets flag an error
  assign pready = 1'b1;
  always_comb
  begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    unique case (paddr)
      bsf_pkg::CTRL_OFS: prdata = {24'h00_0000, ctrl_r};
      bsf_pkg::ADDR_OFS: prdata = addr_r;
      bsf_pkg::WDATA_OFS: prdata = {16'h0000, wdata_r};
      bsf_pkg::RDATA_OFS: prdata = {16'h0000, rdata_r};
      bsf_pkg::STAT_OFS: prdata = {27'h000_0000, pollerr_r, toggle_r, ready_busy_n, done_r, busy};
      bsf_pkg::PINS_OFS: prdata = {16'h0000, poll_cnt_r};
      default: pslverr = psel && penable;
    endcase
  end

  // Control register; writes during a cycle leave the cycle untouched
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_r <= bsf_pkg::CTRL_RST_VAL;
    else if (apb_wr && paddr == bsf_pkg::CTRL_OFS && !busy)
      ctrl_r <= {pwdata[7:1], 1'b0};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_r <= 32'h0000_0000;
      wdata_r <= 16'h0000;
    end
    else if (apb_wr && !busy)
    begin
      if (paddr == bsf_pkg::ADDR_OFS)
        addr_r <= pwdata;
      if (paddr == bsf_pkg::WDATA_OFS)
        wdata_r <= pwdata[15:0];
    end
  end

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_count = SETUP_L;
    unique case (state_r)
      bsf_pkg::ST_IDLE:
        if (go && pwdata[bsf_pkg::CTRL_RST_BIT])
        begin
          state_nxt = bsf_pkg::ST_RESET;
          tmr_load = 1'b1;
          tmr_count = RESET_L;
        end
        else if (go)
        begin
          state_nxt = bsf_pkg::ST_SETUP;
          tmr_load = 1'b1;
          tmr_count = SETUP_L;
        end
      bsf_pkg::ST_SETUP:
        if (tmr_exp)
        begin
          state_nxt = bsf_pkg::ST_STROBE;
          tmr_load = 1'b1;
          tmr_count = is_write ? STROBE_L : ACCESS_L;
        end
      bsf_pkg::ST_STROBE:
        if (tmr_exp)
        begin
          state_nxt = bsf_pkg::ST_HOLD;
          tmr_load = 1'b1;
          tmr_count = HOLD_L;
        end
      bsf_pkg::ST_HOLD:
        if (tmr_exp)
        begin
          // Command writes may start an embedded operation to watch
          if (polling)
          begin
            state_nxt = bsf_pkg::ST_POLL;
            tmr_load = 1'b1;
            tmr_count = ACCESS_L;
          end
          else
            state_nxt = bsf_pkg::ST_IDLE;
        end
      bsf_pkg::ST_POLL:
        // Each poll is a read cycle; stop when the toggle bit stands still and ready_busy_n is high, or at the poll limit
        if (tmr_exp)
        begin
          if (!first_r && (((prev_r ^ dq_in) & 16'h0040) == 16'h0000) && ready_busy_n)
            state_nxt = bsf_pkg::ST_IDLE;
          else if (poll_cnt_r >= 16'(POLL_LIMIT))
            state_nxt = bsf_pkg::ST_IDLE;
          else
          begin
            tmr_load = 1'b1;
            tmr_count = POLL_L;
          end
        end
      bsf_pkg::ST_RESET:
        if (tmr_exp)
          state_nxt = bsf_pkg::ST_IDLE;
      default:
        state_nxt = bsf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= bsf_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  bsf_timer #(
    .W(CNT_W_L)
  ) u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_exp)
  );

  // Read data captured at end of the access window
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= 16'h0000;
    else if ((state_r == bsf_pkg::ST_STROBE && tmr_exp && !is_write) ||
             (state_r == bsf_pkg::ST_POLL && tmr_exp))
      rdata_r <= dq_in & lane_mask;
  end

  // Poll bookkeeping
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_r <= 16'h0000;
      first_r <= 1'b1;
      poll_cnt_r <= 16'h0000;
      toggle_r <= 1'b0;
    end
    else if (state_r == bsf_pkg::ST_HOLD)
    begin
      first_r <= 1'b1;
      poll_cnt_r <= 16'h0000;
    end
    else if (state_r == bsf_pkg::ST_POLL && tmr_exp)
    begin
      prev_r <= dq_in;
      first_r <= 1'b0;
      poll_cnt_r <= poll_cnt_r + 16'h0001;
      toggle_r <= (prev_r[bsf_pkg::TOGGLE_DQ] ^ dq_in[bsf_pkg::TOGGLE_DQ]) ||
                  (prev_r[bsf_pkg::TOGGLE2_DQ] ^ dq_in[bsf_pkg::TOGGLE2_DQ]);
    end
  end

  // Done is sticky; a new start clears it, completion in the same cycle wins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      done_r <= 1'b0;
      pollerr_r <= 1'b0;
    end
    else if (busy && state_nxt == bsf_pkg::ST_IDLE)
    begin
      done_r <= 1'b1;
      pollerr_r <= state_r == bsf_pkg::ST_POLL && poll_cnt_r >= 16'(POLL_LIMIT);
    end
    else if (go)
    begin
      done_r <= 1'b0;
      pollerr_r <= 1'b0;
    end
  end

  // Pin drive, all from flops for clean strobes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flash_addr <= '0;
      chip_sel_n <= 1'b1;
      write_n <= 1'b1;
      out_en_n <= 1'b1;
      dq_out <= 16'h0000;
      dq_oe_n <= 16'hffff;
      flash_reset_n <= 1'b0;
    end
    else
    begin
      flash_addr <= addr_r[ADDR_W-1:0];
      flash_reset_n <= state_nxt != bsf_pkg::ST_RESET;
      // Standby: chip select stays high between cycles
      chip_sel_n <= !(state_nxt inside {bsf_pkg::ST_SETUP, bsf_pkg::ST_STROBE, bsf_pkg::ST_HOLD,
                                       bsf_pkg::ST_POLL}) && ctrl_r[bsf_pkg::CTRL_STBY_BIT] ||
                    state_nxt == bsf_pkg::ST_IDLE || state_nxt == bsf_pkg::ST_RESET;
      // Command and data writes are plain strobed bus writes
      write_n <= !(state_nxt == bsf_pkg::ST_STROBE && is_write);
      // Poll reads release output drive for one cycle so the toggle bits can advance
      out_en_n <= !((state_nxt == bsf_pkg::ST_STROBE && !is_write) ||
                    (state_nxt == bsf_pkg::ST_POLL && !(state_r == bsf_pkg::ST_POLL && tmr_exp)));
      dq_out <= wdata_r & lane_mask;
      // Drive data only in the setup, strobe and hold cycles of a write, never with output enable low
      dq_oe_n <= (is_write && state_nxt inside {bsf_pkg::ST_SETUP, bsf_pkg::ST_STROBE,
                  bsf_pkg::ST_HOLD}) ? ~lane_mask : 16'hffff;
    end
  end

  // Static straps: word/byte select, write protect, acceleration
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      byte_mode_n <= 1'b1;
      write_protect_n <= 1'b1;
      fast_program_input <= 1'b0;
    end
    else
    begin
      byte_mode_n <= !byte_mode;
      write_protect_n <= !ctrl_r[bsf_pkg::CTRL_WP_BIT];
      fast_program_input <= ctrl_r[bsf_pkg::CTRL_ACC_BIT];
    end
  end
endmodule

/* File: hw/bsf_pkg.sv */
// Package for the boot sector flash host controller
package bsf_pkg;
  // Register offsets on APB (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] PINS_OFS = 8'h14;
  // Control register fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_BYTE_BIT = 2;
  localparam int CTRL_STBY_BIT = 3;
  localparam int CTRL_RST_BIT = 4;
  localparam int CTRL_WP_BIT = 5;
  localparam int CTRL_ACC_BIT = 6;
  localparam int CTRL_POLL_BIT = 7;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RDYBSY_BIT = 2;
  localparam int STAT_TOGGLE_BIT = 3;
  localparam int STAT_POLLERR_BIT = 4;
  // Pin-control reset values
  localparam logic [7:0] CTRL_RST_VAL = 8'h00;
  // Bus cycle timing: 250 MHz, 4 ns period
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_NS = 10;
  localparam int ACCESS_NS = 90;
  localparam int STROBE_NS = 35;
  localparam int HOLD_NS = 10;
  localparam int RESET_PULSE_NS = 500;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Data width of the flash bus in each organisation
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  // Polling bits on the data lanes
  localparam int POLL_DQ = 7;
  localparam int TOGGLE_DQ = 6;
  localparam int TOGGLE2_DQ = 2;
  localparam int CNT_W = 8;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_STROBE = 6'b000100,
    ST_HOLD = 6'b001000,
    ST_POLL = 6'b010000,
    ST_RESET = 6'b100000
  } bsf_state_t;
endpackage

/* File: hw/bsf_timer.sv */
// Down-counting cycle timer with one-cycle expiry pulse
`timescale 1ns/100ps
module bsf_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic expired
);
  logic [W-1:0] cnt_r;
  logic run_r;

  if (W < 2)
  begin
    $error("bsf_timer: W too small");
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else if (load)
    begin
      cnt_r <= count;
      run_r <= 1'b1;
    end
    else if (run_r)
    begin
      if (cnt_r <= W'(1))
        run_r <= 1'b0;
      cnt_r <= cnt_r - W'(1);
    end
  end

  // Must not look at load: the sequencer derives load from this pulse
  assign expired = run_r && (cnt_r <= W'(1));
endmodule

/* File: bench/bsf_host_props.sv */
// Port assertions for the flash host controller
`timescale 1ns/100ps
module bsf_host_props #(
  parameter int ADDR_W = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic byte_mode_n,
  input wire logic flash_reset_n,
  input wire logic [15:0] dq_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire xfer = psel && penable;
  chk_zero_wait: assert property (xfer |-> pready)
    else $error("no ready");
  chk_bad_offset: assert property (xfer && paddr > 8'h14 |-> pslverr)
    else $error("no slverr");
  chk_byte_lanes: assert property (!byte_mode_n |-> &dq_oe_n[15:8])
    else $error("upper lane driven");
  chk_no_contention: assert property (!out_en_n |-> &dq_oe_n)
    else $error("bus clash");
  chk_write_select: assert property (!write_n |-> !chip_sel_n && out_en_n)
    else $error("bad write strobe");
  chk_write_width: assert property ($fell(write_n) |-> !write_n [*8] ##1 !write_n ##1 write_n)
    else $error("write width");
  chk_read_width: assert property ($fell(out_en_n) |-> ##22 !out_en_n ##1 out_en_n)
    else $error("read width");
  chk_write_setup: assert property ($fell(write_n) |-> $past(chip_sel_n, 3) == 1'b0)
    else $error("short setup");
  chk_addr_hold: assert property (!write_n || !out_en_n |-> $stable(flash_addr))
    else $error("address moved");
  chk_reset_pulse: assert property ($fell(flash_reset_n) |-> ##124 !flash_reset_n ##1 flash_reset_n)
    else $error("reset width");
  cover property ($fell(write_n));
  cover property ($fell(flash_reset_n));
  cover property (xfer && pslverr);
endmodule

/* File: bench/bsf_flash_model.sv */
// Behavioural boot sector flash facing the host controller
`timescale 1ns/100ps
module bsf_flash_model #(
  parameter int BUSY_CYC = 100
) (
  // Clock for sampling the host pins and for busy timing
  input wire logic clk,
  // Host pins
  input wire logic [21:0] flash_addr,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic byte_mode_n,
  input wire logic flash_reset_n,
  input wire logic write_protect_n,
  input wire logic [15:0] dq_out,
  // Device outputs
  output logic [15:0] dq_in,
  output logic ready_busy_n
);
  // Small array: sectors of 16 words, the lowest eight are boot sectors
  logic [15:0] mem [0:511];
  logic [15:0] pend, wd, v, last_q = '0;
  logic armed = 1'b0, erase_armed = 1'b0, tog = 1'b0, we_d = 1'b1, oe_d = 1'b1;
  int busy = 0, up_cnt = 0;
  wire [8:0] a = flash_addr[8:0];
  wire rd_en = !chip_sel_n && !out_en_n;
  // Supply counts as too low for the first few cycles
  wire low_sup = up_cnt < 8;
  // The two outermost boot sectors sit at the bottom
  wire outer_boot = a[8:5] == 4'h0;
  initial
    foreach (mem[i]) mem[i] = 16'hffff;
  assign v = busy != 0 ? {pend[15:8], ~pend[7], tog, pend[5:3], tog, pend[1:0]} : mem[a];
  // Released lanes float: show the inverse of the last value
  assign dq_in = rd_en ? {byte_mode_n ? v[15:8] : ~last_q[15:8], v[7:0]} : ~last_q;
  assign ready_busy_n = busy == 0;
  always @(posedge clk)
  begin
    we_d <= write_n;
    oe_d <= out_en_n;
    if (low_sup)
      up_cnt <= up_cnt + 1;
    if (!write_n)
      wd <= byte_mode_n ? dq_out : {8'h00, dq_out[7:0]};
    if (rd_en)
      last_q <= dq_in;
    if (oe_d && !out_en_n && busy != 0)
      tog <= ~tog;
    if (busy != 0)
      busy <= busy - 1;
    if (!flash_reset_n)
    begin
      armed <= 1'b0;
      erase_armed <= 1'b0;
      busy <= 0;
    end
    else if (!we_d && write_n && !chip_sel_n && busy == 0 && !low_sup)
    begin
      if (armed && (write_protect_n || !outer_boot))
      begin
        mem[a] <= wd;
        pend <= wd;
        busy <= BUSY_CYC;
      end
      // Erase clears one whole sector and leaves the rest alone
      if (erase_armed && wd[7:0] == 8'h30 && (write_protect_n || !outer_boot))
      begin
        for (int j = 0; j < 16; j++)
          mem[{a[8:4], 4'(j)}] <= 16'hffff;
        pend <= 16'hffff;
        busy <= BUSY_CYC;
      end
      armed <= !armed && wd[7:0] == 8'ha0;
      erase_armed <= !armed && wd[7:0] == 8'h80;
    end
  end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [21:0] flash_addr, a;
  logic chip_sel_n, write_n, out_en_n, byte_mode_n, flash_reset_n, write_protect_n, fast_program_input, ready_busy_n;
  logic [15:0] dq_in, dq_out, dq_oe_n, d;
  logic [15:0] ref_mem [int];
  int errors = 0, checked = 0, cyc = 0, seed = 32'h4624;
  always #2 clk = ~clk;
  bsf_host #(.POLL_LIMIT(8)) u_bsf_host (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
    .byte_mode_n(byte_mode_n), .flash_reset_n(flash_reset_n), .write_protect_n(write_protect_n),
    .fast_program_input(fast_program_input), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .ready_busy_n(ready_busy_n));
  bsf_flash_model u_flash (.clk(clk), .flash_addr(flash_addr), .chip_sel_n(chip_sel_n), .write_n(write_n),
    .out_en_n(out_en_n), .byte_mode_n(byte_mode_n), .flash_reset_n(flash_reset_n),
    .write_protect_n(write_protect_n), .dq_out(dq_out), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One flash cycle; the address write while busy must be dropped
  task automatic op(input logic [7:0] c);
    apb(1'b1, bsf_pkg::ADDR_OFS, {10'h000, a});
    apb(1'b1, bsf_pkg::WDATA_OFS, {16'h0000, d});
    apb(1'b1, bsf_pkg::CTRL_OFS, {24'h000000, c | 8'h01});
    apb(1'b1, bsf_pkg::ADDR_OFS, 32'h0000_00ff);
    do
      apb(1'b0, bsf_pkg::STAT_OFS, 32'h0);
    while (rd[bsf_pkg::STAT_BUSY_BIT] !== 1'b0);
    apb(1'b0, bsf_pkg::ADDR_OFS, 32'h0);
    chk(rd, {10'h000, a});
  endtask
  task automatic prog(input logic [7:0] c);
    logic [15:0] keep;
    keep = d;
    d = 16'h00a0;
    op(c | 8'h02);
    d = keep;
    op(c | 8'h82);
    apb(1'b0, bsf_pkg::STAT_OFS, 32'h0);
    chk(rd[4:0] & 5'h17, 5'h06);
    apb(1'b0, bsf_pkg::PINS_OFS, 32'h0);
    chk(rd[15:0] > 16'h0001, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] m);
    op(c);
    apb(1'b0, bsf_pkg::RDATA_OFS, 32'h0);
    chk(rd[15:0], (ref_mem.exists(a) ? ref_mem[a] : 16'hffff) & m);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, bsf_pkg::CTRL_OFS, 32'h0);
    chk(rd, {24'h000000, bsf_pkg::CTRL_RST_VAL});
    chk({chip_sel_n, flash_reset_n, dq_oe_n}, 18'h3ffff);
    apb(1'b1, 8'h40, 32'h1234_5678);
    chk(err, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      a = 22'($random(seed)) & 22'h0000ff;
      d = 16'($random(seed));
      rd_chk(8'h00, 16'hffff);
      prog(i[0] ? 8'h40 : 8'h00);
      chk(fast_program_input, i[0]);
      ref_mem[a] = d;
      rd_chk(i[1] ? 8'h04 : 8'h00, i[1] ? 16'h00ff : 16'hffff);
    end
    a = 22'h000000;
    d = 16'h1234;
    prog(8'h20);
    rd_chk(8'h00, 16'hffff);
    a = 22'h000111;
    d = 16'h00a0;
    op(8'h02);
    op(8'h10);
    d = 16'h5a5a;
    op(8'h02);
    rd_chk(8'h00, 16'hffff);
    a = 22'h000020;
    d = 16'h1357;
    prog(8'h00);
    ref_mem[a] = d;
    a = 22'h000035;
    d = 16'h2468;
    prog(8'h00);
    ref_mem[a] = d;
    a = 22'h000020;
    d = 16'h0080;
    op(8'h02);
    d = 16'h0030;
    op(8'h82);
    for (int j = 32; j < 48; j++)
      ref_mem.delete(j);
    rd_chk(8'h00, 16'hffff);
    a = 22'h000035;
    rd_chk(8'h00, 16'hffff);
    apb(1'b1, bsf_pkg::CTRL_OFS, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk({chip_sel_n, fast_program_input}, 2'b10);
    end_sim();
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      end_sim();
    end
  end
endmodule
bind bsf_host bsf_host_props #(.ADDR_W(ADDR_W)) u_bsf_host_props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
  .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n), .byte_mode_n(byte_mode_n),
  .flash_reset_n(flash_reset_n), .dq_oe_n(dq_oe_n));
